// ---- design/fbp_flash_block_protection.sv ----
/*
 * Flash array with per-2KB protection: read-only and execute-only marks.
 * Requests come one per cycle from fetch, data or debug; each answers in
 * the same cycle's following edge. Protection marks are plain inputs.
 */
`default_nettype none
// Contract
// R1 - 128 KB flash, independently erasable 1 KB units
// R2 - Erase sets every bit of unit
// R3 - Protection per 2 KB pair, independent
// R4 - Read-only units refuse erase and program
// R5 - Execute-only units refuse erase and program
// R6 - Execute-only reads served only to fetch
// R7 - Reads complete in one clock cycle
// R8 - Refusal sets sticky flag, returns bus error
module fbp_flash_block_protection
    import fbp_pkg::*;
(
    input  wire logic                   i_core_clk,
    input  wire logic                   i_rst_n,
    input  wire logic                   i_clk_en,
    input  wire logic                   i_req_valid,
    input  wire fbp_pkg::fbp_op_t       i_req_op,
    input  wire fbp_pkg::fbp_src_t      i_req_src,
    input  wire logic [fbp_pkg::ADDR_W-1:0] i_req_addr,
    input  wire logic [fbp_pkg::DATA_W-1:0] i_req_wdata,
    input  wire logic [fbp_pkg::NUM_PU-1:0] i_prot_ro,
    input  wire logic [fbp_pkg::NUM_PU-1:0] i_prot_xo,
    input  wire logic                   i_err_clr,
    output logic                        o_rsp_valid,
    output logic                        o_rsp_err,
    output logic [fbp_pkg::DATA_W-1:0]  o_rsp_rdata,
    output logic                        o_err_sticky
);
    import fbp_pkg::*;

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [DATA_W-1:0] mem_q [NUM_WORDS]; // R1

    function automatic logic [PU_W-1:0] pu_of(
        input logic [ADDR_W-1:0] a);
        pu_of = a[ADDR_W-1:PU_LSB]; // R3
    endfunction

    function automatic logic [EU_W-1:0] eu_of(
        input logic [ADDR_W-1:0] a);
        eu_of = a[ADDR_W-1:EU_OFS_W];
    endfunction

    // ------------------------------------------------------------
    // Access check
    // ------------------------------------------------------------
    logic              ro_hit;
    logic              xo_hit;
    logic              is_wr;
    logic              deny;
    logic              do_rd;
    logic              do_prog;
    logic              do_erase;

    always_comb begin
        ro_hit   = i_prot_ro[pu_of(i_req_addr)];
        xo_hit   = i_prot_xo[pu_of(i_req_addr)];
        is_wr    = (i_req_op == FBP_OP_PROG) || (i_req_op == FBP_OP_ERASE);
        deny     = 1'b0;
        if (i_req_valid && is_wr && ro_hit) begin
            deny = 1'b1; // R4
        end
        if (i_req_valid && is_wr && xo_hit) begin
            deny = 1'b1; // R5
        end
        if (i_req_valid && (i_req_op == FBP_OP_READ) && xo_hit
            && (i_req_src != FBP_SRC_FETCH)) begin
            deny = 1'b1; // R6
        end
        do_rd    = i_req_valid && !deny && (i_req_op == FBP_OP_READ);
        do_prog  = i_req_valid && !deny && (i_req_op == FBP_OP_PROG);
        do_erase = i_req_valid && !deny && (i_req_op == FBP_OP_ERASE);
    end

    // ------------------------------------------------------------
    // Response and sticky flag
    // ------------------------------------------------------------
    logic              rsp_valid_d, rsp_valid_q;
    logic              rsp_err_d, rsp_err_q;
    logic [DATA_W-1:0] rdata_d, rdata_q;
    logic              err_d, err_q;

    always_comb begin
        rsp_valid_d = i_req_valid && (i_req_op != FBP_OP_NONE); // R7
        rsp_err_d   = deny; // R8
        rdata_d     = do_rd ? mem_q[i_req_addr] : '0; // R7
        err_d       = err_q;
        if (i_err_clr) begin
            err_d = 1'b0;
        end
        if (deny) begin
            err_d = 1'b1; // R8
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rsp_valid_q <= 1'b0;
            rsp_err_q   <= 1'b0;
            rdata_q     <= '0;
            err_q       <= 1'b0;
        end else if (i_clk_en) begin
            rsp_valid_q <= rsp_valid_d;
            rsp_err_q   <= rsp_err_d;
            rdata_q     <= rdata_d;
            err_q       <= err_d;
        end
    end

    // ------------------------------------------------------------
    // Array update: program clears bits, erase sets a whole unit
    // ------------------------------------------------------------
    always_ff @(posedge i_core_clk) begin
        if (i_clk_en) begin
            for (int w = 0; w < NUM_WORDS; w++) begin
                if (do_erase && (eu_of(ADDR_W'(w)) == eu_of(i_req_addr)))
                begin
                    mem_q[w] <= ERASED_WORD; // R2
                end else if (do_prog && (ADDR_W'(w) == i_req_addr)) begin
                    mem_q[w] <= mem_q[w] & i_req_wdata;
                end
            end
        end
    end

    assign o_rsp_valid  = rsp_valid_q;
    assign o_rsp_err    = rsp_err_q;
    assign o_rsp_rdata  = rdata_q;
    assign o_err_sticky = err_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_ro_no_write: assert property (@(posedge i_core_clk) // R4
        disable iff (!i_rst_n)
        i_clk_en && i_req_valid && ro_hit && is_wr
        |=> o_rsp_valid && o_rsp_err)
        else $error("write to read-only unit not refused");

    a_xo_no_write: assert property (@(posedge i_core_clk) // R5
        disable iff (!i_rst_n)
        i_clk_en && i_req_valid && xo_hit && is_wr |=> o_rsp_err)
        else $error("write to execute-only unit not refused");

    a_xo_data_read: assert property (@(posedge i_core_clk) // R6
        disable iff (!i_rst_n)
        i_clk_en && i_req_valid && xo_hit && i_req_op == FBP_OP_READ
        |=> o_rsp_err == ($past(i_req_src) != FBP_SRC_FETCH))
        else $error("execute-only read filter wrong");

    a_read_one_cycle: assert property (@(posedge i_core_clk) // R7
        disable iff (!i_rst_n)
        i_clk_en && i_req_valid && i_req_op == FBP_OP_READ |=> o_rsp_valid)
        else $error("read not answered in one cycle");

    a_err_sticky_set: assert property (@(posedge i_core_clk) // R8
        disable iff (!i_rst_n)
        i_clk_en && deny |=> o_err_sticky)
        else $error("sticky error not set");

    a_err_holds: assert property (@(posedge i_core_clk) // R8
        disable iff (!i_rst_n)
        o_err_sticky && !i_err_clr |=> o_err_sticky)
        else $error("sticky error lost");

    a_erase_ones: assert property (@(posedge i_core_clk) // R2
        disable iff (!i_rst_n)
        i_clk_en && do_erase ##1 i_clk_en && i_req_valid
        && i_req_op == FBP_OP_READ && !deny
        && eu_of(i_req_addr) == eu_of($past(i_req_addr))
        |=> o_rsp_rdata == ERASED_WORD)
        else $error("erased unit not all ones");

    a_ok_no_err: assert property (@(posedge i_core_clk) // R3
        disable iff (!i_rst_n)
        i_clk_en && i_req_valid && !ro_hit && !xo_hit
        && i_req_op != FBP_OP_NONE |=> o_rsp_valid && !o_rsp_err)
        else $error("unprotected access refused");

    a_idle_no_rsp: assert property (@(posedge i_core_clk) // R7
        disable iff (!i_rst_n)
        i_clk_en && !(i_req_valid && i_req_op != FBP_OP_NONE)
        |=> !o_rsp_valid)
        else $error("response without request");

    a_fetch_served: assert property (@(posedge i_core_clk) // R6
        disable iff (!i_rst_n)
        i_clk_en && i_req_valid && i_req_op == FBP_OP_READ
        && i_req_src == FBP_SRC_FETCH |=> o_rsp_valid && !o_rsp_err)
        else $error("fetch read refused");

    a_ro_read_ok: assert property (@(posedge i_core_clk) // R4
        disable iff (!i_rst_n)
        i_clk_en && i_req_valid && i_req_op == FBP_OP_READ
        && ro_hit && !xo_hit |=> o_rsp_valid && !o_rsp_err)
        else $error("read of read-only unit refused");

    a_deny_no_data: assert property (@(posedge i_core_clk) // R8
        disable iff (!i_rst_n)
        i_clk_en && deny |=> o_rsp_err && o_rsp_rdata == '0)
        else $error("refused access returned data");

    a_clr_clears: assert property (@(posedge i_core_clk) // R8
        disable iff (!i_rst_n)
        i_clk_en && i_err_clr && !deny |=> !o_err_sticky)
        else $error("sticky error not cleared");

    a_freeze_err: assert property (@(posedge i_core_clk) // R8
        disable iff (!i_rst_n)
        !i_clk_en |=> $stable(o_err_sticky))
        else $error("sticky error moved while frozen");
endmodule
`default_nettype wire

// ---- design/fbp_pkg.sv ----
/*
 * Constants for the flash block protection logic: array geometry,
 * request source encoding and request kinds.
 * Assumes a single system clock and a word-wide flash array.
 */
`default_nettype none
package fbp_pkg;
    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int FLASH_KB       = 128;
    localparam int ERASE_UNIT_KB  = 1;
    localparam int PROT_UNIT_KB   = 2;
    localparam int WORD_BYTES     = 4;
    localparam int DATA_W         = 32;
    localparam int WORDS_PER_EU   = ERASE_UNIT_KB * 1024 / WORD_BYTES;
    localparam int NUM_EU         = FLASH_KB / ERASE_UNIT_KB;
    localparam int NUM_PU         = FLASH_KB / PROT_UNIT_KB;
    localparam int NUM_WORDS      = NUM_EU * WORDS_PER_EU;
    localparam int ADDR_W         = $clog2(NUM_WORDS);
    localparam int EU_W           = $clog2(NUM_EU);
    localparam int PU_W           = $clog2(NUM_PU);
    localparam int EU_OFS_W       = $clog2(WORDS_PER_EU);
    localparam int PU_LSB         = EU_OFS_W + 1;
    localparam logic [DATA_W-1:0] ERASED_WORD = 32'hFFFFFFFF;

    // ------------------------------------------------------------
    // Request kinds and attributes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        FBP_OP_READ, FBP_OP_PROG, FBP_OP_ERASE, FBP_OP_NONE
    } fbp_op_t;
    typedef enum logic [1:0] {
        FBP_SRC_FETCH, FBP_SRC_DATA, FBP_SRC_DEBUG, FBP_SRC_RSVD
    } fbp_src_t;
endpackage
`default_nettype wire

// ---- tb/fbp_requester.sv ----
/* Requester model: fetch, data and debug masters of the flash.
   Assumes its tasks are called just after a falling clock edge. */
`default_nettype none
module fbp_requester
    import fbp_pkg::*;
(
    output var logic                         o_valid,
    output var fbp_pkg::fbp_op_t             o_op,
    output var fbp_pkg::fbp_src_t            o_src,
    output var logic [fbp_pkg::ADDR_W-1:0]   o_addr,
    output var logic [fbp_pkg::DATA_W-1:0]   o_wdata
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        o_valid = 1'b0;
        o_op = FBP_OP_NONE;
        o_src = FBP_SRC_RSVD;
        o_addr = '0;
        o_wdata = '0;
    end
    task issue(input fbp_op_t op, input fbp_src_t src,
               input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        o_valid = 1'b1;
        o_op = op;
        o_src = src;
        o_addr = a;
        o_wdata = d;
    endtask
    // Released bus shows no stale request
    task release_bus;
        o_valid = 1'b0;
        o_op = FBP_OP_NONE;
        o_addr = ~o_addr;
        o_wdata = ~o_wdata;
    endtask
endmodule
`default_nettype wire

// ---- tb/fbp_flash_block_protection_tb_top.sv ----
/* Bench for flash block protection: request table, then sticky tests.
   Assumes the requester model drives the request port. */
`default_nettype none
module fbp_flash_block_protection_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import fbp_pkg::*;
    typedef struct {
        logic pr; fbp_op_t op; fbp_src_t src;
        logic [ADDR_W-1:0] a; logic [DATA_W-1:0] d; logic e;
    } fbp_row_t;
    logic clk, rst_n, valid, clr, rv, re, st, exp_st, en;
    fbp_op_t op;
    fbp_src_t src;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rd;
    logic [NUM_PU-1:0] ro, xo;
    int fails, num_checks, cyc;
    fbp_row_t rows [18] = '{
        '{0, FBP_OP_ERASE, FBP_SRC_DATA, 15'h0000, 32'h0, 0},
        '{0, FBP_OP_READ, FBP_SRC_FETCH, 15'h00FF, 32'hFFFFFFFF, 0},
        '{0, FBP_OP_PROG, FBP_SRC_DATA, 15'h0005, 32'hA5A5A5A5, 0},
        '{0, FBP_OP_READ, FBP_SRC_DEBUG, 15'h0005, 32'hA5A5A5A5, 0},
        '{0, FBP_OP_ERASE, FBP_SRC_DATA, 15'h0100, 32'h0, 0},
        '{0, FBP_OP_READ, FBP_SRC_DATA, 15'h0005, 32'hA5A5A5A5, 0},
        '{0, FBP_OP_ERASE, FBP_SRC_DATA, 15'h0200, 32'h0, 0},
        '{0, FBP_OP_ERASE, FBP_SRC_DATA, 15'h0400, 32'h0, 0},
        '{0, FBP_OP_PROG, FBP_SRC_DATA, 15'h0400, 32'hC3C3C3C3, 0},
        '{1, FBP_OP_ERASE, FBP_SRC_DATA, 15'h0200, 32'h0, 1},
        '{1, FBP_OP_PROG, FBP_SRC_DATA, 15'h02FF, 32'h0, 1},
        '{1, FBP_OP_READ, FBP_SRC_DATA, 15'h02FF, 32'hFFFFFFFF, 0},
        '{1, FBP_OP_ERASE, FBP_SRC_DEBUG, 15'h0400, 32'h0, 1},
        '{1, FBP_OP_PROG, FBP_SRC_DATA, 15'h0400, 32'h0, 1},
        '{1, FBP_OP_READ, FBP_SRC_FETCH, 15'h0400, 32'hC3C3C3C3, 0},
        '{1, FBP_OP_READ, FBP_SRC_DATA, 15'h0400, 32'h0, 1},
        '{1, FBP_OP_READ, FBP_SRC_DEBUG, 15'h05FF, 32'h0, 1},
        '{1, FBP_OP_READ, FBP_SRC_DATA, 15'h0005, 32'hA5A5A5A5, 0}};
    fbp_requester fbp_requester_i (.o_valid(valid), .o_op(op),
        .o_src(src), .o_addr(addr), .o_wdata(wdata));
    fbp_flash_block_protection fbp_flash_block_protection_i (
        .i_core_clk(clk), .i_rst_n(rst_n), .i_clk_en(en),
        .i_req_valid(valid), .i_req_op(op), .i_req_src(src),
        .i_req_addr(addr), .i_req_wdata(wdata), .i_prot_ro(ro),
        .i_prot_xo(xo), .i_err_clr(clr), .o_rsp_valid(rv),
        .o_rsp_err(re), .o_rsp_rdata(rd), .o_err_sticky(st));
    task check(input string n, input logic [63:0] s, input logic [63:0] e);
        num_checks++;
        if (s !== e) begin
            fails++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    task finish_test;
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial cyc = 0;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            fails++;
            finish_test;
        end
    end
    initial begin
        rst_n = 1'b0;
        clr = 1'b0;
        en = 1'b1;
        ro = '0;
        xo = '0;
        fails = 0;
        num_checks = 0;
        exp_st = 1'b0;
        repeat (10) @(negedge clk);
        check("reset", {rv, re, st, rd}, 35'h0);
        rst_n = 1'b1;
        foreach (rows[i]) begin
            ro = rows[i].pr ? 64'h2 : 64'h0;
            xo = rows[i].pr ? 64'h4 : 64'h0;
            fbp_requester_i.issue(rows[i].op, rows[i].src, rows[i].a,
                                  rows[i].d);
            @(negedge clk);
            exp_st = exp_st | rows[i].e;
            check("valid", rv, 1'b1);
            check("err", re, rows[i].e);
            check("rdata", rd, (rows[i].op == FBP_OP_READ && !rows[i].e)
                  ? rows[i].d : 32'h0);
            check("sticky", st, exp_st);
        end
        fbp_requester_i.release_bus;
        clr = 1'b1;
        @(negedge clk);
        check("idle", rv, 1'b0);
        check("clr", st, 1'b0);
        fbp_requester_i.issue(FBP_OP_ERASE, FBP_SRC_DATA, 15'h0200, 32'h0);
        @(negedge clk);
        check("setwin", {re, st}, 2'h3);
        clr = 1'b0;
        fbp_requester_i.release_bus;
        @(negedge clk);
        check("hold", st, 1'b1);
        check("holdrsp", {rv, re}, 2'h0);
        en = 1'b0;
        clr = 1'b1;
        fbp_requester_i.issue(FBP_OP_PROG, FBP_SRC_DATA, 15'h0005, 32'h0);
        @(negedge clk);
        check("frozen", {rv, st}, 2'h1);
        en = 1'b1;
        clr = 1'b0;
        fbp_requester_i.issue(FBP_OP_READ, FBP_SRC_DATA, 15'h0005, 32'h0);
        @(negedge clk);
        check("frzdata", {rv, re, st, rd}, {3'b101, 32'hA5A5A5A5});
        fbp_requester_i.release_bus;
        rst_n = 1'b0;
        @(negedge clk);
        check("reset2", {rv, re, st, rd}, 35'h0);
        rst_n = 1'b1;
        fbp_requester_i.issue(FBP_OP_READ, FBP_SRC_FETCH, 15'h0005, 32'h0);
        @(negedge clk);
        check("keep", {rv, re, st, rd}, {3'b100, 32'hA5A5A5A5});
        finish_test;
    end
endmodule
`default_nettype wire
